// ===== hdl/crlc_pkg.sv
// package for the comparator reference ladder control block
// assumes a 32-bit ahb-lite register bus and a 32-point analog ladder
package crlc_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int unsigned AddrW = 16;
  localparam logic [AddrW-1:0] CtrlBase = 16'h9000;
  localparam logic [AddrW-1:0] AliasClr = 16'h0004;
  localparam logic [AddrW-1:0] AliasSet = 16'h0008;
  localparam logic [AddrW-1:0] AliasInv = 16'h000c;
  localparam logic [31:0] CtrlReset = 32'h0000_0000;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned EnableBit = 15;
  localparam int unsigned PinOeBit = 6;
  localparam int unsigned RangeBit = 5;
  localparam int unsigned SourceBit = 4;
  localparam int unsigned TapLsb = 0;
  localparam int unsigned TapW = 4;
  localparam logic [31:0] CtrlImplMask = 32'h0000_807f;
  // ---------------------------------------------------------------
  // ladder geometry
  // ---------------------------------------------------------------
  localparam int unsigned LowRangeSteps = 24;
  localparam int unsigned HighRangeSteps = 32;
  localparam int unsigned HighRangeOffset = 8;
  localparam int unsigned SegW = 5;
  // ---------------------------------------------------------------
  // ahb-lite codes
  // ---------------------------------------------------------------
  localparam logic [1:0] HtransNonseq = 2'b10;
  localparam logic [1:0] HtransSeq = 2'b11;
  localparam logic [2:0] HsizeWord = 3'b010;
  // write operation kinds
  typedef enum logic [3:0] {
    CRLC_WR_PLAIN = 4'b0001,
    CRLC_WR_CLR = 4'b0010,
    CRLC_WR_SET = 4'b0100,
    CRLC_WR_INV = 4'b1000
  } crlc_wrop_e;
endpackage

// ===== hdl/crlc_ladder_decode.sv
// ladder switch decoder: turns control fields into one-hot tap selects
// assumes the analog ladder has one switch per segment point
`timescale 1ns/1ps
module crlc_ladder_decode #(
  parameter int unsigned SEGS = 32
) (
  // control fields
  input wire logic enable,
  input wire logic rangeLow,
  input wire logic [crlc_pkg::TapW-1:0] tapCode,
  // switch selects
  output logic [SEGS-1:0] tapSelect
);
  import crlc_pkg::*;

  // elaboration check: high range needs offset plus all codes
  if (SEGS < HighRangeOffset + (1 << TapW)) begin : gShortLadder
    $error("ladder too short for the high range");
  end

  // ---------------------------------------------------------------
  // low range taps point k of 24, high range point 8+k of 32
  // ---------------------------------------------------------------
  logic [SegW-1:0] point;

  always_comb begin
    if (rangeLow) begin
      point = SegW'(tapCode);
    end else begin
      point = SegW'(tapCode) + SegW'(HighRangeOffset);
    end
    tapSelect = '0;
    if (enable) begin
      tapSelect[point] = 1'b1;
    end
  end
endmodule

// ===== hdl/crlc_top.sv
// comparator reference ladder control: ahb-lite register and switches
// assumes one clock, a single-slave ahb-lite bus and an analog ladder
// Summary of operation
// (R01) bit 15 powers ladder; other fields keep their values
// (R02) bit 6 connects reference level to the output pin
// (R03) range bit one: low range, steps of one twenty-fourth
// (R04) range bit zero: high range, quarter offset, one thirty-second
// (R05) bit 4 selects external reference pins or analog supply
// (R06) four-bit tap code in bits 3..0 picks the ladder tap
// (R07) clear, set, invert aliases at base plus 4, 8, 12
// (R08) unimplemented bits read zero, ignore writes; reset zero
// (R09) software avoids access right after clearing enable
// (R10) while disabled all ladder and pin switches stay off
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
module crlc_top #(
  parameter int unsigned SEGS = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [crlc_pkg::AddrW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // ladder switch controls
  output logic ladderPowerOn,
  output logic sourceExternal,
  output logic sourceSupply,
  output logic rangeLowSel,
  output logic [SEGS-1:0] ladderTapSelect,
  output logic refPinConnect
);
  import crlc_pkg::*;

  // elaboration check: select index must reach every segment
  if (SEGS > (1 << SegW)) begin : gBadSegs
    $error("segment count exceeds select width");
  end

  // ---------------------------------------------------------------
  // address phase capture
  // ---------------------------------------------------------------
  logic wrPend_q;
  logic [AddrW-1:0] wrAddr_q;
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  crlc_wrop_e op;

  function automatic logic isCtrl(input logic [AddrW-1:0] a);
    return (a & ~AliasInv) == CtrlBase;
  endfunction

  wire logic accept = hsel && hready &&
    (htrans == HtransNonseq || htrans == HtransSeq);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= '0;
    end else begin
      wrPend_q <= accept && hwrite && hsize == HsizeWord;
      wrAddr_q <= haddr;
    end
  end

  // ---------------------------------------------------------------
  // register write with alias decode
  // ---------------------------------------------------------------
  always_comb begin
    op = CRLC_WR_PLAIN;
    if (wrAddr_q - CtrlBase == AliasClr) begin
      op = CRLC_WR_CLR;
    end else if (wrAddr_q - CtrlBase == AliasSet) begin
      op = CRLC_WR_SET;
    end else if (wrAddr_q - CtrlBase == AliasInv) begin
      op = CRLC_WR_INV;
    end
    ctrl_d = ctrl_q;
    if (wrPend_q && isCtrl(wrAddr_q)) begin
      case (op)
        CRLC_WR_CLR: ctrl_d = ctrl_q & ~hwdata; // [R07]
        CRLC_WR_SET: ctrl_d = ctrl_q | hwdata; // [R07]
        CRLC_WR_INV: ctrl_d = ctrl_q ^ hwdata; // [R07]
        default: ctrl_d = hwdata;
      endcase
      ctrl_d = ctrl_d & CtrlImplMask; // [R08]
    end
  end

  // enable is just another field: others kept as written [R01]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CtrlReset; // [R08]
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ---------------------------------------------------------------
  // read data and response; zero wait state, always okay
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= '0;
    end else if (accept && !hwrite && isCtrl(haddr)) begin
      hrdata <= ctrl_d; // [R08]
    end else if (accept) begin
      hrdata <= '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // ladder controls, all gated by enable
  // ---------------------------------------------------------------
  wire logic en = ctrl_d[EnableBit];
  logic [SEGS-1:0] tapSel;

  crlc_ladder_decode #(
    .SEGS(SEGS)
  ) u_decode (
    .enable(en), // [R10]
    .rangeLow(ctrl_d[RangeBit]), // [R03] [R04]
    .tapCode(ctrl_d[TapLsb +: TapW]), // [R06]
    .tapSelect(tapSel)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ladderPowerOn <= 1'b0;
      sourceExternal <= 1'b0;
      sourceSupply <= 1'b0;
      rangeLowSel <= 1'b0;
      ladderTapSelect <= '0;
      refPinConnect <= 1'b0;
    end else begin
      ladderPowerOn <= en; // [R01]
      sourceExternal <= en && ctrl_d[SourceBit]; // [R05] [R10]
      sourceSupply <= en && !ctrl_d[SourceBit]; // [R05] [R10]
      rangeLowSel <= en && ctrl_d[RangeBit]; // [R03] [R10]
      ladderTapSelect <= tapSel; // [R06]
      refPinConnect <= en && ctrl_d[PinOeBit]; // [R02] [R10]
    end
  end
endmodule

// ===== verif/crlc_top_props.sv
// checker: assertions on the reference ladder control ports
// assumes one clock domain, zero-wait bus and 32 segment points
`timescale 1ns/1ps
module crlc_top_props #(
  parameter int unsigned SEGS = 32
) (
  // clock, reset and bus
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic hready,
  input wire logic hwrite,
  input wire logic [1:0] htrans,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // ladder controls
  input wire logic ladderPowerOn,
  input wire logic sourceExternal,
  input wire logic sourceSupply,
  input wire logic rangeLowSel,
  input wire logic [SEGS-1:0] ladderTapSelect,
  input wire logic refPinConnect
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  off_gates_a: assert property (!ladderPowerOn |->
    !(sourceExternal | sourceSupply | rangeLowSel | refPinConnect)
    && ladderTapSelect == '0) else $error("switch on while off");
  src_excl_a: assert property (ladderPowerOn |->
    sourceExternal ^ sourceSupply) else $error("source select bad");
  tap_hot_a: assert property (ladderPowerOn |->
    $onehot(ladderTapSelect)) else $error("tap not one-hot");
  low_tap_a: assert property (ladderPowerOn && rangeLowSel |->
    ladderTapSelect[SEGS-1:16] == '0) else $error("low tap range");
  high_tap_a: assert property (ladderPowerOn && !rangeLowSel |->
    ladderTapSelect[7:0] == '0 && ladderTapSelect[SEGS-1:24] == '0)
    else $error("high tap range");
  rsv_zero_a: assert property (hrdata[31:16] == '0 &&
    hrdata[14:7] == '0) else $error("reserved bits set");
  bus_ok_a: assert property (hreadyout && !hresp)
    else $error("bus answer bad");
  out_hold_a: assert property (
    !$past(hsel && hready && htrans[1] && hwrite, 2) |->
    $stable({ladderPowerOn, refPinConnect, ladderTapSelect}))
    else $error("switch moved without write");
endmodule
bind crlc_top crlc_top_props #(.SEGS(SEGS)) u_props (.clk(clk),
  .rst_n(rst_n), .hsel(hsel), .hready(hready), .hwrite(hwrite),
  .htrans(htrans), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .ladderPowerOn(ladderPowerOn),
  .sourceExternal(sourceExternal), .sourceSupply(sourceSupply),
  .rangeLowSel(rangeLowSel), .ladderTapSelect(ladderTapSelect),
  .refPinConnect(refPinConnect));

// ===== verif/crlc_top_tb.sv
// testbench: register accesses and ladder switch checks
// assumes zero-wait ahb-lite slave and 32 segment points
`timescale 1ns/1ps
module crlc_top_tb;
  logic clk = 0, rst_n = 0, hsel = 1, hwrite = 0, hready;
  logic [15:0] haddr = 16'h0000;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, pwr, ext, sup, low, pin;
  logic [31:0] tap;
  int failures = 0, tests_run = 0;
  logic [79:0] rows [9] = '{{16'h9000, 32'hffffffff, 32'h807f},
    {16'h9004, 32'h8000, 32'h007f}, {16'h9008, 32'h8000, 32'h807f},
    {16'h900c, 32'h0021, 32'h805e}, {16'h9000, 32'h8020, 32'h8020},
    {16'h9000, 32'h800f, 32'h800f}, {16'h9000, 32'h802f, 32'h802f},
    {16'h9000, 32'h8050, 32'h8050}, {16'h9000, 32'h0, 32'h0}};
  assign hready = hreadyout;
  crlc_top DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ladderPowerOn(pwr), .sourceExternal(ext),
    .sourceSupply(sup), .rangeLowSel(low), .ladderTapSelect(tap),
    .refPinConnect(pin));
  initial forever #2.5 clk = ~clk;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task cmp(input logic [39:0] g, input logic [39:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wt;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      failures++;
      report_and_stop;
    end
  endtask
  task xfer(input logic w, input logic [15:0] a, input logic [2:0] s,
      input logic [31:0] d);
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= s;
    wt;
    htrans <= 2'b00;
    hwdata <= d;
    wt;
    rd = hrdata;
  endtask
  function automatic logic [39:0] expo(input logic [31:0] r);
    logic [4:0] i;
    i = r[5] ? {1'b0, r[3:0]} : r[3:0] + 5'd8;
    return {3'b0, r[15], {r[4], !r[4], r[5], r[6]} & {4{r[15]}},
      r[15] ? 32'h1 << i : 32'h0};
  endfunction
  task chk(input logic [15:0] a, input logic [31:0] e);
    xfer(0, a, 3'b010, 32'h0);
    cmp({8'h0, rd}, {8'h0, e});
    cmp({3'b0, pwr, ext, sup, low, pin, tap}, expo(e));
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    chk(16'h9000, 32'h0);
    foreach (rows[k]) begin
      xfer(1, rows[k][79:64], 3'b010, rows[k][63:32]);
      // no access in the cycle after a write that may clear enable
      @(posedge clk);
      chk(16'h9000, rows[k][31:0]);
    end
    xfer(1, 16'h9000, 3'b000, 32'h80ff);
    chk(16'h9000, 32'h0);
    xfer(1, 16'h8000, 3'b010, 32'hffff);
    chk(16'h8000, 32'h0);
    xfer(1, 16'h9000, 3'b010, 32'h8041);
    chk(16'h900c, 32'h8041);
    rst_n <= 0;
    @(posedge clk);
    cmp({3'b0, pwr, ext, sup, low, pin, tap}, 40'h0);
    rst_n <= 1;
    @(posedge clk);
    chk(16'h9000, 32'h0);
    report_and_stop;
  end
endmodule
